//--- inc/utxrx_consts.svh
// constants for the transmitter/receiver enable command block
`ifndef UTXRX_CONSTS_SVH
`define UTXRX_CONSTS_SVH
`define UTXRX_ADDR_W       4
`define UTXRX_OFS_CMD      4'h0
`define UTXRX_OFS_STATUS   4'h1
`define UTXRX_OFS_CONFIG   4'h2
`define UTXRX_OFS_IRQ_STAT 4'h3
`define UTXRX_OFS_IRQ_MASK 4'h4
`define UTXRX_TC_LSB       2
`define UTXRX_RC_LSB       0
`define UTXRX_CODE_NONE    2'h0
`define UTXRX_CODE_ENABLE  2'h1
`define UTXRX_CODE_DISABLE 2'h2
`define UTXRX_PM_MULTIDROP 2'h3
`define UTXRX_CFG_RESET    8'h00
`define UTXRX_EV_W         4
`endif

//--- inc/utxrx_pkg.sv
// types for the transmitter/receiver enable command block
package utxrx_pkg;
   typedef enum logic [2:0] {
      UTXRX_TX_OFF   = 3'h1,
      UTXRX_TX_ON    = 3'h2,
      UTXRX_TX_DRAIN = 3'h4
   } utxrx_tx_state_t;
   typedef enum logic [2:0] {
      UTXRX_RX_OFF    = 3'h1,
      UTXRX_RX_SEARCH = 3'h2,
      UTXRX_RX_FINISH = 3'h4
   } utxrx_rx_state_t;
endpackage : utxrx_pkg

//--- logic/utxrx_cmd_decode.sv
// command field decoder: at most one strobe per field per write
`timescale 1ns/10ps
`default_nettype none
`include "utxrx_consts.svh"
module utxrx_cmd_decode (
   input  wire logic       cmd_wr,
   input  wire logic [7:0] cmd_data,
   output logic            tx_enable_cmd,
   output logic            tx_disable_cmd,
   output logic            rx_enable_cmd,
   output logic            rx_disable_cmd
);
   logic [1:0] tx_command_field;
   logic [1:0] rx_command_field;
   // field split; code 00 and reserved 11 produce no strobe
   always_comb begin
      tx_command_field = cmd_data[`UTXRX_TC_LSB +: 2];
      rx_command_field = cmd_data[`UTXRX_RC_LSB +: 2];
      tx_enable_cmd    = cmd_wr && (tx_command_field == `UTXRX_CODE_ENABLE);
      tx_disable_cmd   = cmd_wr && (tx_command_field == `UTXRX_CODE_DISABLE);
      rx_enable_cmd    = cmd_wr && (rx_command_field == `UTXRX_CODE_ENABLE);
      rx_disable_cmd   = cmd_wr && (rx_command_field == `UTXRX_CODE_DISABLE);
   end
endmodule : utxrx_cmd_decode
`default_nettype wire

//--- logic/utxrx_enable_ctrl.sv
// transmitter/receiver enable command control with status and interrupt
//
// Function
// - tx command bits 3-2 pick one command; 00 keeps transmitter state.
// - tx code 01 enables transmitter, sets tx empty and ready; no-op if on.
// - modem mode enable sets no flags; empty set at first frame sync if unwritten.
// - ac97 empty needs fifo empty, enabled, codec ready, sync before samples.
// - tx code 10 stops after current character, clears empty and ready.
// - modem mode disable keeps tx ready unless remote loop-back or echo.
// - rx command bits 1-0 pick one command; 00 keeps receiver state.
// - rx code 01 outside multidrop enables receiver into start bit search.
// - rx code 10 disables at once, drops character, keeps status.
// - local loop-back or multidrop keeps receiver running despite disable.
// - modem mode rx disable lets an arriving character finish first.
// - async mode buffer writes ignored while not ready or disabled.
`timescale 1ns/10ps
`default_nettype none
`include "utxrx_consts.svh"
module utxrx_enable_ctrl (
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   input  wire logic [`UTXRX_ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]               reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output logic      [7:0]               reg_rdata,
   input  wire logic                     shift_busy,
   input  wire logic                     rx_char_active,
   input  wire logic                     tx_fifo_empty,
   input  wire logic                     tx_buf_wr,
   input  wire logic                     tx_shift_load,
   input  wire logic                     frame_sync,
   input  wire logic                     codec_ready,
   output logic                          tx_enabled,
   output logic                          rx_enabled,
   output logic                          rx_search_start,
   output logic                          tx_buf_accept,
   output logic                          irq
);
   ////////////////////////////////////////////////////////////////////////
   // configuration register: mode bits steering command effects
   // bit0 modem, bit1 ac97, bit2 local loop, bit3 remote loop, bit4 echo, 6:5 parity mode
   logic [7:0] config_r;
   logic [7:0] config_nxt;
   logic       modem_mode;
   logic       ac97_mode;
   logic       local_loop;
   logic       remote_or_echo;
   logic       multidrop;
   logic [1:0] parity_mode_field;

   always_comb begin
      modem_mode        = config_r[0];
      ac97_mode         = config_r[1] & config_r[0];
      local_loop        = config_r[2];
      remote_or_echo    = config_r[3] | config_r[4];
      parity_mode_field = config_r[6:5];
      multidrop         = (parity_mode_field == `UTXRX_PM_MULTIDROP);
   end

   ////////////////////////////////////////////////////////////////////////
   // command decode
   logic cmd_wr;
   logic tx_en_cmd;
   logic tx_dis_cmd;
   logic rx_en_cmd;
   logic rx_dis_cmd;

   assign cmd_wr = reg_wr && (reg_addr == `UTXRX_OFS_CMD);

   utxrx_cmd_decode u_dec (
      .cmd_wr         (cmd_wr),
      .cmd_data       (reg_wdata),
      .tx_enable_cmd  (tx_en_cmd),
      .tx_disable_cmd (tx_dis_cmd),
      .rx_enable_cmd  (rx_en_cmd),
      .rx_disable_cmd (rx_dis_cmd)
   );

   ////////////////////////////////////////////////////////////////////////
   // transmitter state and status flags
   utxrx_pkg::utxrx_tx_state_t tx_state_r;
   utxrx_pkg::utxrx_tx_state_t tx_state_nxt;
   logic tx_empty_flag_r;
   logic tx_empty_flag_nxt;
   logic tx_ready_flag_r;
   logic tx_ready_flag_nxt;
   logic wait_sync_r;
   logic wait_sync_nxt;
   logic tx_on;
   logic tx_buf_accept_r;
   logic tx_buf_accept_nxt;

   always_comb begin
      tx_state_nxt      = tx_state_r;
      tx_empty_flag_nxt = tx_empty_flag_r;
      tx_ready_flag_nxt = tx_ready_flag_r;
      wait_sync_nxt     = wait_sync_r;
      tx_on             = (tx_state_r == utxrx_pkg::UTXRX_TX_ON);
      // buffer traffic
      if (tx_buf_accept_r && tx_buf_wr) begin
         tx_ready_flag_nxt = 1'b0;
         tx_empty_flag_nxt = 1'b0;
      end
      if (tx_on && tx_shift_load && !modem_mode)
         tx_ready_flag_nxt = 1'b1;
      if (modem_mode && tx_buf_wr)
         wait_sync_nxt = 1'b0;
      // first frame sync after enable with nothing written
      if (modem_mode && wait_sync_r && frame_sync && tx_fifo_empty
          && (!ac97_mode || codec_ready)) begin
         tx_empty_flag_nxt = 1'b1;
         wait_sync_nxt     = 1'b0;
      end
      case (tx_state_r)
         utxrx_pkg::UTXRX_TX_OFF: begin
            if (tx_en_cmd) begin
               tx_state_nxt = utxrx_pkg::UTXRX_TX_ON;
               if (modem_mode) begin
                  wait_sync_nxt = 1'b1;
               end else begin
                  tx_empty_flag_nxt = 1'b1;
                  tx_ready_flag_nxt = 1'b1;
               end
            end
         end
         utxrx_pkg::UTXRX_TX_ON: begin
            if (tx_dis_cmd) begin
               tx_state_nxt      = shift_busy ? utxrx_pkg::UTXRX_TX_DRAIN : utxrx_pkg::UTXRX_TX_OFF;
               tx_empty_flag_nxt = 1'b0;
               wait_sync_nxt     = 1'b0;
               if (!modem_mode || remote_or_echo)
                  tx_ready_flag_nxt = 1'b0;
            end
         end
         utxrx_pkg::UTXRX_TX_DRAIN: begin
            if (!shift_busy)
               tx_state_nxt = utxrx_pkg::UTXRX_TX_OFF;
         end
         default: tx_state_nxt = utxrx_pkg::UTXRX_TX_OFF;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // receiver state
   utxrx_pkg::utxrx_rx_state_t rx_state_r;
   utxrx_pkg::utxrx_rx_state_t rx_state_nxt;
   logic rx_keep_on;

   always_comb begin
      rx_state_nxt = rx_state_r;
      rx_keep_on   = local_loop || multidrop;
      case (rx_state_r)
         utxrx_pkg::UTXRX_RX_OFF: begin
            if (rx_en_cmd && !multidrop)
               rx_state_nxt = utxrx_pkg::UTXRX_RX_SEARCH;
         end
         utxrx_pkg::UTXRX_RX_SEARCH: begin
            if (rx_dis_cmd && !rx_keep_on) begin
               if (modem_mode && rx_char_active)
                  rx_state_nxt = utxrx_pkg::UTXRX_RX_FINISH;
               else
                  rx_state_nxt = utxrx_pkg::UTXRX_RX_OFF;
            end
         end
         utxrx_pkg::UTXRX_RX_FINISH: begin
            if (!rx_char_active)
               rx_state_nxt = utxrx_pkg::UTXRX_RX_OFF;
         end
         default: rx_state_nxt = utxrx_pkg::UTXRX_RX_OFF;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // buffer acceptance gate

   always_comb begin
      if (modem_mode)
         tx_buf_accept_nxt = 1'b1;
      else
         tx_buf_accept_nxt = (tx_state_nxt == utxrx_pkg::UTXRX_TX_ON) && tx_ready_flag_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt events: tx enabled, tx empty rise, tx ready rise, rx disabled
   logic [`UTXRX_EV_W-1:0] irq_stat_r;
   logic [`UTXRX_EV_W-1:0] irq_stat_nxt;
   logic [`UTXRX_EV_W-1:0] irq_mask_r;
   logic [`UTXRX_EV_W-1:0] irq_mask_nxt;
   logic [`UTXRX_EV_W-1:0] events;
   logic                   irq_nxt;

   always_comb begin
      events[0] = (tx_state_nxt == utxrx_pkg::UTXRX_TX_ON) && (tx_state_r != utxrx_pkg::UTXRX_TX_ON);
      events[1] = tx_empty_flag_nxt && !tx_empty_flag_r;
      events[2] = tx_ready_flag_nxt && !tx_ready_flag_r;
      events[3] = (rx_state_nxt == utxrx_pkg::UTXRX_RX_OFF) && (rx_state_r != utxrx_pkg::UTXRX_RX_OFF);
      irq_stat_nxt = irq_stat_r;
      irq_mask_nxt = irq_mask_r;
      config_nxt   = config_r;
      if (reg_wr && reg_addr == `UTXRX_OFS_IRQ_STAT)
         irq_stat_nxt = irq_stat_r & ~reg_wdata[`UTXRX_EV_W-1:0];
      irq_stat_nxt = irq_stat_nxt | events;                      // set wins over clear
      if (reg_wr && reg_addr == `UTXRX_OFS_IRQ_MASK)
         irq_mask_nxt = reg_wdata[`UTXRX_EV_W-1:0];
      if (reg_wr && reg_addr == `UTXRX_OFS_CONFIG)
         config_nxt = {1'b0, reg_wdata[6:0]};
      irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
   end

   ////////////////////////////////////////////////////////////////////////
   // read data, one cycle after the strobe
   logic [7:0] rdata_nxt;

   always_comb begin
      rdata_nxt = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            `UTXRX_OFS_STATUS:   rdata_nxt = {3'h0, (rx_state_r != utxrx_pkg::UTXRX_RX_OFF),
                                              (tx_state_r != utxrx_pkg::UTXRX_TX_OFF), wait_sync_r,
                                              tx_empty_flag_r, tx_ready_flag_r};
            `UTXRX_OFS_CONFIG:   rdata_nxt = config_r;
            `UTXRX_OFS_IRQ_STAT: rdata_nxt = {4'h0, irq_stat_r};
            `UTXRX_OFS_IRQ_MASK: rdata_nxt = {4'h0, irq_mask_r};
            default:             rdata_nxt = 8'h00;              // command is write-only
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         config_r        <= `UTXRX_CFG_RESET;
         tx_state_r      <= utxrx_pkg::UTXRX_TX_OFF;
         rx_state_r      <= utxrx_pkg::UTXRX_RX_OFF;
         tx_empty_flag_r <= 1'b0;
         tx_ready_flag_r <= 1'b0;
         wait_sync_r     <= 1'b0;
         tx_buf_accept_r <= 1'b0;
         irq_stat_r      <= 4'h0;
         irq_mask_r      <= 4'h0;
         irq             <= 1'b0;
         reg_rdata       <= 8'h00;
         tx_enabled      <= 1'b0;
         rx_enabled      <= 1'b0;
         rx_search_start <= 1'b0;
      end else begin
         config_r        <= config_nxt;
         tx_state_r      <= tx_state_nxt;
         rx_state_r      <= rx_state_nxt;
         tx_empty_flag_r <= tx_empty_flag_nxt;
         tx_ready_flag_r <= tx_ready_flag_nxt;
         wait_sync_r     <= wait_sync_nxt;
         tx_buf_accept_r <= tx_buf_accept_nxt;
         irq_stat_r      <= irq_stat_nxt;
         irq_mask_r      <= irq_mask_nxt;
         irq             <= irq_nxt;
         reg_rdata       <= rdata_nxt;
         tx_enabled      <= (tx_state_nxt != utxrx_pkg::UTXRX_TX_OFF);
         rx_enabled      <= (rx_state_nxt != utxrx_pkg::UTXRX_RX_OFF) || rx_keep_on;
         rx_search_start <= (rx_state_r == utxrx_pkg::UTXRX_RX_OFF)
                            && (rx_state_nxt == utxrx_pkg::UTXRX_RX_SEARCH);
      end
   end

   assign tx_buf_accept = tx_buf_accept_r;
endmodule : utxrx_enable_ctrl
`default_nettype wire

//--- tb/utxrx_enable_ctrl_assertions.sv
// checker for the enable command control block
`timescale 1ns/10ps
`default_nettype none
`include "utxrx_consts.svh"
module utxrx_enable_ctrl_chk (
   input wire logic                     clk,
   input wire logic                     reset_n,
   input wire logic [`UTXRX_ADDR_W-1:0] reg_addr,
   input wire logic [7:0]               reg_wdata,
   input wire logic                     reg_wr,
   input wire logic                     reg_rd,
   input wire logic [7:0]               reg_rdata,
   input wire logic                     shift_busy,
   input wire logic                     rx_char_active,
   input wire logic                     tx_enabled,
   input wire logic                     rx_enabled,
   input wire logic                     rx_search_start,
   input wire logic                     irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic cmd_w;
   ////////////////////////////////////////////////
   // command register write in this cycle
   assign cmd_w = reg_wr && (reg_addr == `UTXRX_OFS_CMD);
   // read data, command strobes and drain behaviour
   property p_cmd_rd; reg_rd && reg_addr == `UTXRX_OFS_CMD |=> reg_rdata == 8'h00; endproperty
   a_cmd_rd: assert property (p_cmd_rd) else $error("command read not zero");
   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   property p_tx_rise; $rose(tx_enabled) |-> $past(cmd_w && reg_wdata[3:2] == 2'h1); endproperty
   a_tx_rise: assert property (p_tx_rise) else $error("tx on without enable");
   property p_tx_drain; tx_enabled && shift_busy |=> tx_enabled; endproperty
   a_tx_drain: assert property (p_tx_drain) else $error("tx off mid character");
   property p_tx_nop; cmd_w && reg_wdata[3:2] != 2'h1 && !tx_enabled |=> !tx_enabled; endproperty
   a_tx_nop: assert property (p_tx_nop) else $error("tx on without enable code");
   property p_rx_fall;
      $fell(rx_enabled) |-> $past(cmd_w && reg_wdata[1:0] == 2'h2) || !$past(rx_char_active);
   endproperty
   a_rx_fall: assert property (p_rx_fall) else $error("rx off without cause");
   property p_rx_search; rx_search_start |-> $past(cmd_w && reg_wdata[1:0] == 2'h1); endproperty
   a_rx_search: assert property (p_rx_search) else $error("search without enable");
   property p_search_on; rx_search_start |-> rx_enabled ##1 !rx_search_start; endproperty
   a_search_on: assert property (p_search_on) else $error("search pulse wrong");
   c_search: cover property (rx_search_start);
   c_drain: cover property (tx_enabled && shift_busy);
   c_irq: cover property (irq);
endmodule : utxrx_enable_ctrl_chk
bind utxrx_enable_ctrl utxrx_enable_ctrl_chk i_chk (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .shift_busy(shift_busy),
   .rx_char_active(rx_char_active), .tx_enabled(tx_enabled), .rx_enabled(rx_enabled),
   .rx_search_start(rx_search_start), .irq(irq));
`default_nettype wire

//--- tb/utxrx_peer.sv
// serial peer model: shifter, receive activity, frame sync
`timescale 1ns/10ps
`default_nettype none
module utxrx_peer #(
   parameter int CHAR_CYC = 10
) (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic tx_start,
   input  wire logic rx_start,
   input  wire logic sync_req,
   output logic      shift_busy,
   output logic      tx_shift_load,
   output logic      rx_char_active,
   output logic      frame_sync
);
   int tx_cnt_r;
   int rx_cnt_r;
   // character timers; shifter load and sync are one-cycle pulses
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_cnt_r      <= 0;
         rx_cnt_r      <= 0;
         tx_shift_load <= 1'b0;
         frame_sync    <= 1'b0;
      end else begin
         tx_cnt_r      <= tx_start ? CHAR_CYC : (tx_cnt_r > 0 ? tx_cnt_r - 1 : 0);
         rx_cnt_r      <= rx_start ? CHAR_CYC : (rx_cnt_r > 0 ? rx_cnt_r - 1 : 0);
         tx_shift_load <= tx_start;
         frame_sync    <= sync_req;
      end
   end
   assign shift_busy     = (tx_cnt_r != 0);
   assign rx_char_active = (rx_cnt_r != 0);
endmodule : utxrx_peer
`default_nettype wire

//--- tb/utxrx_tb.sv
// self-checking bench for the enable command control block
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic       clk, reset_n, reg_wr, reg_rd, tx_fifo_empty, tx_buf_wr, codec_ready;
   logic       tx_start, rx_start, sync_req, shift_busy, tx_shift_load, rx_char_active, frame_sync;
   logic       tx_enabled, rx_enabled, rx_search_start, tx_buf_accept, irq;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   int         miscompares, num_checks, cycles;
   utxrx_peer i_peer (.clk(clk), .reset_n(reset_n), .tx_start(tx_start), .rx_start(rx_start),
      .sync_req(sync_req), .shift_busy(shift_busy), .tx_shift_load(tx_shift_load),
      .rx_char_active(rx_char_active), .frame_sync(frame_sync));
   utxrx_enable_ctrl i_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .shift_busy(shift_busy),
      .rx_char_active(rx_char_active), .tx_fifo_empty(tx_fifo_empty), .tx_buf_wr(tx_buf_wr),
      .tx_shift_load(tx_shift_load), .frame_sync(frame_sync), .codec_ready(codec_ready),
      .tx_enabled(tx_enabled), .rx_enabled(rx_enabled), .rx_search_start(rx_search_start),
      .tx_buf_accept(tx_buf_accept), .irq(irq));
   ////////////////////////////////////////////////
   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         give_verdict();
      end
   end
   ////////////////////////////////////////////////
   // compare, bus and pulse tasks
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask : chk
   // command writes never use code 11 nor conflicting commands
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(n, e, reg_rdata & m);
   endtask : rd
   // 0 buffer write, 1 tx char, 2 rx char, 3 frame sync
   task automatic pulse(input int w);
      @(posedge clk);
      {sync_req, rx_start, tx_start, tx_buf_wr} <= 4'h1 << w;
      @(posedge clk);
      {sync_req, rx_start, tx_start, tx_buf_wr} <= 4'h0;
      #1;
   endtask : pulse
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : idle
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   ////////////////////////////////////////////////
   // test sequence
   initial begin
      {reset_n, reg_wr, reg_rd, tx_buf_wr, codec_ready, tx_start, rx_start, sync_req} = 8'h00;
      tx_fifo_empty = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      wr(4'h0, 8'h05);
      chk("search", 8'h01, rx_search_start);
      rd(4'h1, 8'hFF, 8'h1B, "status");
      wr(4'h0, 8'h05);
      chk("search", 8'h00, rx_search_start);
      wr(4'h0, 8'h00);
      rd(4'h1, 8'hFF, 8'h1B, "status");
      rd(4'h0, 8'hFF, 8'h00, "cmd");
      rd(4'h7, 8'hFF, 8'h00, "unmapped");
      chk("accept", 8'h01, tx_buf_accept);
      pulse(0);
      chk("accept", 8'h00, tx_buf_accept);
      rd(4'h3, 8'hFF, 8'h07, "irq_stat");
      chk("irq", 8'h00, irq);
      wr(4'h4, 8'h02);
      rd(4'h4, 8'hFF, 8'h02, "irq_mask");
      chk("irq", 8'h01, irq);
      wr(4'h3, 8'h02);
      rd(4'h3, 8'hFF, 8'h05, "irq_stat");
      chk("irq", 8'h00, irq);
      pulse(1);
      wr(4'h0, 8'h08);
      chk("tx_en", 8'h01, tx_enabled);
      rd(4'h1, 8'h03, 8'h00, "status");
      idle(12);
      chk("tx_en", 8'h00, tx_enabled);
      chk("accept", 8'h00, tx_buf_accept);
      pulse(2);
      wr(4'h0, 8'h02);
      chk("rx_en", 8'h00, rx_enabled);
      rd(4'h3, 8'h08, 8'h08, "irq_stat");
      $display("test async done");
      wr(4'h2, 8'h01);
      wr(4'h0, 8'h05);
      rd(4'h1, 8'h03, 8'h00, "status");
      pulse(2);
      wr(4'h0, 8'h02);
      chk("rx_en", 8'h01, rx_enabled);
      pulse(3);
      rd(4'h1, 8'h03, 8'h02, "status");
      wr(4'h0, 8'h08);
      rd(4'h1, 8'h02, 8'h00, "status");
      idle(12);
      chk("rx_en", 8'h00, rx_enabled);
      $display("test modem done");
      wr(4'h2, 8'h03);
      wr(4'h0, 8'h04);
      pulse(3);
      rd(4'h1, 8'h02, 8'h00, "status");
      @(posedge clk) codec_ready <= 1'b1;
      pulse(3);
      rd(4'h1, 8'h02, 8'h02, "status");
      $display("test codec done");
      wr(4'h0, 8'h08);
      wr(4'h2, 8'h00);
      wr(4'h0, 8'h04);
      wr(4'h2, 8'h01);
      wr(4'h0, 8'h08);
      rd(4'h1, 8'h03, 8'h01, "status");
      wr(4'h2, 8'h09);
      wr(4'h0, 8'h04);
      rd(4'h1, 8'h03, 8'h01, "status");
      wr(4'h0, 8'h08);
      rd(4'h1, 8'h03, 8'h00, "status");
      wr(4'h0, 8'h04);
      pulse(0);
      pulse(3);
      rd(4'h1, 8'h07, 8'h00, "status");
      wr(4'h2, 8'h03);
      wr(4'h0, 8'h08);
      wr(4'h0, 8'h04);
      @(posedge clk) tx_fifo_empty <= 1'b0;
      pulse(3);
      rd(4'h1, 8'h02, 8'h00, "status");
      @(posedge clk) tx_fifo_empty <= 1'b1;
      pulse(3);
      rd(4'h1, 8'h02, 8'h02, "status");
      $display("test modem flags done");
      wr(4'h2, 8'h04);
      wr(4'h0, 8'h01);
      wr(4'h0, 8'h02);
      chk("rx_en", 8'h01, rx_enabled);
      wr(4'h2, 8'h00);
      wr(4'h0, 8'h02);
      wr(4'h2, 8'h60);
      wr(4'h0, 8'h01);
      chk("search", 8'h00, rx_search_start);
      wr(4'h0, 8'h02);
      chk("rx_en", 8'h01, rx_enabled);
      $display("test loop done");
      give_verdict();
   end
endmodule : tb
`default_nettype wire
